// File: logic/asr_flag_unit.sv
/*
  flag computation for the arithmetic status register.
  assumes operands arrive valid in the same cycle as the operation code.
*/
`timescale 1ns/1ns
module asr_flag_unit #(
  parameter int WIDTH = 8
) (
  // operation
  input wire asr_pkg::asr_op_type op_in,
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] b_in,
  // flags and result
  output logic carry_out,
  output logic nibble_carry_out,
  output logic zero_out,
  output logic [WIDTH-1:0] result_out
);

  // the nibble carry taps bit 3; datapaths narrower than five bits are rejected
  if (WIDTH < 5) begin : g_width_check
    $error("asr_flag_unit needs at least five bits");
  end

  wire logic is_sub;
  wire logic [WIDTH-1:0] b_eff;
  wire logic [WIDTH:0] sum_full;
  wire logic [4:0] nib_sum;

  assign is_sub = (op_in == asr_pkg::ASR_OP_SUB);
  // subtraction adds the two's complement, so carry 1 means no borrow
  assign b_eff = is_sub ? ~b_in : b_in;
  assign sum_full = {1'b0, a_in} + {1'b0, b_eff} + {{WIDTH{1'b0}}, is_sub};
  assign nib_sum = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};

  always_comb begin
    result_out = sum_full[WIDTH-1:0];
    carry_out = sum_full[WIDTH];
    nibble_carry_out = nib_sum[4];
    zero_out = (sum_full[WIDTH-1:0] == '0);
    if (op_in == asr_pkg::ASR_OP_LOGIC) begin
      result_out = a_in;
      zero_out = (a_in == '0);
    end
  end

endmodule

// File: logic/asr_pkg.sv
/*
  package for the arithmetic status register block: offsets, bit positions,
  reset values and the flag-update operation codes.
  assumes a single core clock and an active-low power-on reset.
*/
package asr_pkg;

  // ---------------------------------------------------------------
  // register placement
  // ---------------------------------------------------------------
  localparam logic [8:0] ASR_OFFSET_B0 = 9'h003;
  localparam logic [8:0] ASR_OFFSET_B1 = 9'h083;
  localparam logic [8:0] ASR_OFFSET_B2 = 9'h103;
  localparam logic [8:0] ASR_OFFSET_B3 = 9'h183;
  localparam logic [6:0] ASR_OFFSET_LOW = 7'h03;

  // ---------------------------------------------------------------
  // bit positions
  // ---------------------------------------------------------------
  localparam int ASR_BIT_CARRY = 0;
  localparam int ASR_BIT_NIBBLE = 1;
  localparam int ASR_BIT_ZERO = 2;
  localparam int ASR_BIT_SLEEP = 3;
  localparam int ASR_BIT_WDOG = 4;
  localparam int ASR_BIT_DBANK_LO = 5;
  localparam int ASR_BIT_DBANK_HI = 6;
  localparam int ASR_BIT_IBANK = 7;

  // ---------------------------------------------------------------
  // reset value, write masks and clear result
  // ---------------------------------------------------------------
  localparam logic [7:0] ASR_RESET_VALUE = 8'h18;
  localparam logic [7:0] ASR_WRITABLE_MASK = 8'he7;
  localparam logic [7:0] ASR_ARITH_MASK = 8'h07;
  localparam logic [7:0] ASR_CLEAR_RESULT = 8'h04;

  // ---------------------------------------------------------------
  // flag-update operations from the datapath
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ASR_OP_NONE = 3'h0,
    ASR_OP_ADD = 3'h1,
    ASR_OP_SUB = 3'h2,
    ASR_OP_LOGIC = 3'h3,
    ASR_OP_CLEAR = 3'h4
  } asr_op_type;

endpackage

// File: logic/asr_status_reg.sv
/*
  arithmetic status register: carry, nibble carry and zero flags, reset
  status flags and the bank-select bits, plus bank address generation.
  assumes the instruction datapath drives one operation per cycle and that
  software reaches the register through the plain read/write port.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns

module asr_status_reg (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [8:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // datapath flag update
  input wire asr_pkg::asr_op_type op_in,
  input wire logic [7:0] op_a_in,
  input wire logic [7:0] op_b_in,
  output logic [7:0] result_out,
  // reset-status events
  input wire logic wdog_clear_in,
  input wire logic sleep_in,
  input wire logic wdog_timeout_in,
  // addressing
  input wire logic [6:0] direct_addr_in,
  input wire logic [7:0] indirect_addr_in,
  output logic [8:0] direct_full_addr_out,
  output logic [8:0] indirect_full_addr_out,
  // status view
  output logic [7:0] status_out
);

  // ---------------------------------------------------------------
  // flag computation
  // ---------------------------------------------------------------
  wire logic fu_carry;
  wire logic fu_nibble;
  wire logic fu_zero;
  wire logic [7:0] fu_result;

  asr_flag_unit #(
    .WIDTH(8)
  ) u_flags (
    .op_in(op_in),
    .a_in(op_a_in),
    .b_in(op_b_in),
    .carry_out(fu_carry),
    .nibble_carry_out(fu_nibble),
    .zero_out(fu_zero),
    .result_out(fu_result)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] rdata_r;
  logic [7:0] result_r;
  logic [8:0] dfull_r;
  logic [8:0] ifull_r;

  wire logic hit;
  wire logic sw_write;
  wire logic sw_read;
  wire logic is_arith;
  wire logic is_add_sub;
  wire logic is_clear;
  wire logic [7:0] arith_flags;
  wire logic [7:0] sw_value;

  // same low offset in every bank
  assign hit = (addr_in[6:0] == asr_pkg::ASR_OFFSET_LOW);
  assign sw_write = wr_in && hit;
  assign sw_read = rd_in && hit;
  assign is_add_sub = (op_in == asr_pkg::ASR_OP_ADD) ||
                      (op_in == asr_pkg::ASR_OP_SUB);
  assign is_arith = is_add_sub || (op_in == asr_pkg::ASR_OP_LOGIC);
  assign is_clear = (op_in == asr_pkg::ASR_OP_CLEAR);
  assign arith_flags = {5'h00, fu_zero,
                        is_add_sub ? fu_nibble : status_r[1],
                        is_add_sub ? fu_carry : status_r[0]};
  // reset-status bits never take software data
  assign sw_value = (wdata_in & asr_pkg::ASR_WRITABLE_MASK) |
                    (status_r & ~asr_pkg::ASR_WRITABLE_MASK);

  // ---------------------------------------------------------------
  // next value
  // ---------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    if (sw_write && is_clear) begin
      // clear result 000u u1uu
      status_nxt = (status_r & 8'h1b) | asr_pkg::ASR_CLEAR_RESULT;
    end else if (sw_write) begin
      status_nxt = sw_value;
    end
    if (is_arith) begin
      // flag logic wins over the written flag bits
      status_nxt = (status_nxt & ~asr_pkg::ASR_ARITH_MASK) |
                   arith_flags;
    end
    // reset-status events come from core logic, not from data writes
    if (wdog_clear_in) begin
      status_nxt[asr_pkg::ASR_BIT_WDOG] = 1'b1;
      status_nxt[asr_pkg::ASR_BIT_SLEEP] = 1'b1;
    end else if (sleep_in) begin
      status_nxt[asr_pkg::ASR_BIT_WDOG] = 1'b1;
      status_nxt[asr_pkg::ASR_BIT_SLEEP] = 1'b0;
    end
    if (wdog_timeout_in) begin
      status_nxt[asr_pkg::ASR_BIT_WDOG] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bank address generation
  // ---------------------------------------------------------------
  wire logic [8:0] dfull_nxt;
  wire logic [8:0] ifull_nxt;

  assign dfull_nxt = {status_nxt[asr_pkg::ASR_BIT_DBANK_HI],
                      status_nxt[asr_pkg::ASR_BIT_DBANK_LO],
                      direct_addr_in};
  assign ifull_nxt = {status_nxt[asr_pkg::ASR_BIT_IBANK],
                      indirect_addr_in};

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_r <= asr_pkg::ASR_RESET_VALUE;
      rdata_r <= 8'h00;
      result_r <= 8'h00;
      dfull_r <= 9'h000;
      ifull_r <= 9'h000;
    end else begin
      status_r <= status_nxt;
      rdata_r <= sw_read ? status_r : 8'h00;
      result_r <= fu_result;
      dfull_r <= dfull_nxt;
      ifull_r <= ifull_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign result_out = result_r;
  assign direct_full_addr_out = dfull_r;
  assign indirect_full_addr_out = ifull_r;
  assign status_out = status_r;

endmodule

// File: test/asr_status_reg_checker.sv
/* assertions on the status register ports.
   bound to every asr_status_reg instance. */
`timescale 1ns/1ns
module asr_status_reg_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // watched ports
  input wire logic [8:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire asr_pkg::asr_op_type op_in,
  input wire logic [7:0] op_a_in,
  input wire logic [7:0] op_b_in,
  input wire logic [7:0] result_out,
  input wire logic wdog_clear_in,
  input wire logic sleep_in,
  input wire logic wdog_timeout_in,
  input wire logic [6:0] direct_addr_in,
  input wire logic [8:0] direct_full_addr_out,
  input wire logic [7:0] indirect_addr_in,
  input wire logic [8:0] indirect_full_addr_out,
  input wire logic [7:0] status_out
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  wire hit = addr_in[6:0] == asr_pkg::ASR_OFFSET_LOW;
  wire quiet = !wdog_clear_in && !sleep_in && !wdog_timeout_in;
  wire none = op_in == asr_pkg::ASR_OP_NONE;
  wire [8:0] sum = {1'b0, op_a_in} + {1'b0, op_b_in};
  wire [4:0] nib = {1'b0, op_a_in[3:0]} + {1'b0, op_b_in[3:0]};
  wire [1:0] ge = {op_a_in[3:0] >= op_b_in[3:0], op_a_in >= op_b_in};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_wdog_ro: assert property (wr_in && hit && quiet |=>
    $stable(status_out[4:3])) else $error("reset flags took a write");
  a_write_bank: assert property (wr_in && hit && none |=>
    (status_out & 8'he7) == ($past(wdata_in) & 8'he7))
    else $error("written bits differ");
  a_clear_file: assert property (wr_in && hit && quiet &&
    op_in == asr_pkg::ASR_OP_CLEAR |=>
    status_out == (($past(status_out) & 8'h1b) | 8'h04))
    else $error("clear-file result wrong");
  a_sleep_event: assert property (sleep_in && !wdog_clear_in
    && !wdog_timeout_in |=> status_out[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_add_carry: assert property (op_in == asr_pkg::ASR_OP_ADD |=>
    status_out[1:0] == {$past(nib[4]), $past(sum[8])})
    else $error("add carries wrong");
  a_sub_borrow: assert property (op_in == asr_pkg::ASR_OP_SUB |=>
    status_out[1:0] == $past(ge)) else $error("sub borrows wrong");
  a_zero_flag: assert property (!none &&
    op_in != asr_pkg::ASR_OP_CLEAR |=>
    status_out[2] == (result_out == 8'h00)) else $error("zero flag wrong");
  a_read_data: assert property (rd_in && hit |=>
    rdata_out == $past(status_out)) else $error("read data wrong");
  a_direct_addr: assert property (1'b1 |=>
    direct_full_addr_out == {status_out[6:5], $past(direct_addr_in)})
    else $error("direct address wrong");
  a_indirect_addr: assert property (1'b1 |=>
    indirect_full_addr_out == {status_out[7], $past(indirect_addr_in)})
    else $error("indirect address wrong");
endmodule
bind asr_status_reg asr_status_reg_checker i_chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .op_in(op_in),
  .op_a_in(op_a_in), .op_b_in(op_b_in), .result_out(result_out),
  .wdog_clear_in(wdog_clear_in), .sleep_in(sleep_in),
  .wdog_timeout_in(wdog_timeout_in), .direct_addr_in(direct_addr_in),
  .direct_full_addr_out(direct_full_addr_out),
  .indirect_addr_in(indirect_addr_in),
  .indirect_full_addr_out(indirect_full_addr_out), .status_out(status_out));

// File: test/asr_status_reg_test.sv
/* self-checking bench for the status register.
   drives every port directly; the checker is bound alongside. */
`timescale 1ns/1ns
module asr_status_reg_test;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [8:0] addr_in = 9'h000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  asr_pkg::asr_op_type op_in = asr_pkg::ASR_OP_NONE;
  asr_pkg::asr_op_type o;
  logic [7:0] op_a_in = 8'h00;
  logic [7:0] op_b_in = 8'h00;
  logic [2:0] ev = 3'h0;
  logic [6:0] direct_addr_in = 7'h55;
  logic [7:0] indirect_addr_in = 8'haa;
  logic [7:0] rdata_out, result_out, status_out, d, res, exp;
  logic [8:0] direct_full_addr_out, indirect_full_addr_out;
  logic [7:0] av [8] = '{8'hff, 8'h08, 8'h70, 8'h9a,
    8'h05, 8'h03, 8'h10, 8'h07};
  logic [7:0] bv [8] = '{8'h01, 8'h08, 8'h10, 8'h77,
    8'h03, 8'h05, 8'h01, 8'h07};
  int failures = 0;
  int checked = 0;
  asr_status_reg i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .op_in(op_in), .op_a_in(op_a_in),
    .op_b_in(op_b_in), .result_out(result_out), .wdog_clear_in(ev[2]),
    .sleep_in(ev[1]), .wdog_timeout_in(ev[0]),
    .direct_addr_in(direct_addr_in), .indirect_addr_in(indirect_addr_in),
    .direct_full_addr_out(direct_full_addr_out),
    .indirect_full_addr_out(indirect_full_addr_out), .status_out(status_out));
  always #25 clk_in = ~clk_in;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // one request cycle; flags and writes land at the next edge
  task automatic step(input logic w, input logic [8:0] ad,
    input logic [7:0] dat, input asr_pkg::asr_op_type op,
    input logic [7:0] a, input logic [7:0] b, input logic [2:0] e);
    @(posedge clk_in);
    wr_in <= w;
    addr_in <= ad;
    wdata_in <= dat;
    op_in <= op;
    op_a_in <= a;
    op_b_in <= b;
    ev <= e;
    @(posedge clk_in);
    wr_in <= 1'b0;
    op_in <= asr_pkg::ASR_OP_NONE;
    ev <= 3'h0;
    #1;
  endtask
  task automatic rd(input logic [8:0] ad, input logic [7:0] want);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= ad;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(rdata_out, want);
  endtask
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(9'h003, asr_pkg::ASR_RESET_VALUE);
    for (int i = 0; i < 4; i++) begin
      d = 8'(8'h24 * (i + 1));
      step(1'b1, 9'(9'h003 + i * 128), d, o.first(), 8'h0, 8'h0, 3'h0);
      rd(9'(9'h003 + i * 128), (d & 8'he7) | 8'h18);
    end
    rd(9'h004, 8'h00);
    step(1'b1, 9'h003, 8'h00, o.first(), 8'h00, 8'h00, 3'h2);
    check(status_out, 8'h10);
    step(1'b0, 9'h000, 8'h00, o.first(), 8'h00, 8'h00, 3'h1);
    check(status_out, 8'h00);
    step(1'b1, 9'h103, 8'hff, o.first(), 8'h00, 8'h00, 3'h0);
    check(status_out, 8'he7);
    step(1'b0, 9'h000, 8'h00, o.first(), 8'h00, 8'h00, 3'h4);
    check(status_out, 8'hff);
    step(1'b1, 9'h183, 8'hff, asr_pkg::ASR_OP_CLEAR, 8'h0, 8'h0, 3'h0);
    check(status_out, 8'h1f);
    for (int i = 0; i < 8; i++) begin
      o = i < 4 ? asr_pkg::ASR_OP_ADD : asr_pkg::ASR_OP_SUB;
      res = i < 4 ? av[i] + bv[i] : av[i] - bv[i];
      if (i < 4) exp = {5'h03, res == 8'h00, av[i][3:0] > ~bv[i][3:0],
        av[i] > ~bv[i]};
      else exp = {5'h03, res == 8'h00, av[i][3:0] >= bv[i][3:0],
        av[i] >= bv[i]};
      step(i[0], 9'h003, 8'h00, o, av[i], bv[i], 3'h0);
      check(result_out, res);
      check(status_out, exp);
    end
    step(1'b0, 9'h0, 8'h0, asr_pkg::ASR_OP_LOGIC, 8'h05, 8'h0, 3'h0);
    check(status_out, 8'h1b);
    for (int i = 0; i < 4; i++) begin
      step(1'b1, 9'h083, {i[0], i[1:0], 5'h00}, o.first(), 8'h0, 8'h0, 3'h0);
      step(1'b0, 9'h000, 8'h00, o.first(), 8'h00, 8'h00, 3'h0);
      check(direct_full_addr_out[8:1], {i[1:0], 6'h2a});
      check(indirect_full_addr_out[8:1], {i[0], 7'h55});
    end
    reset_n_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check(status_out, asr_pkg::ASR_RESET_VALUE);
    finish_test();
  end
endmodule
